// File: exposure_trigger_control.sv
// Exposure trigger control: picks a trigger, aligns start, times exposure
// Assumes trigger inputs and readout signals are synchronous to clk_sys
`timescale 1ns/1ps
`include "exposure_trigger_control_defs.svh"
module exposure_trigger_control (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic softTrigger,
    input wire logic first_trigger_input,
    input wire logic secondTriggerInput,
    input wire logic timedTrigger,
    input wire logic [`SRC_W-1:0] triggerSource,
    input wire logic srcOverride,
    input wire logic [`EXP_W-1:0] exposureCycles,
    input wire logic [`EXP_W-1:0] storedExposure,
    input wire logic storedValid,
    input wire logic frameValid,
    input wire logic lineValid,
    output logic exposureActive,
    output logic exposureDone,
    output logic triggerMissed
);
    exposure_timer_if tmr();

    logic [`SRC_W-1:0] activeSource;
    logic hwLevel;
    logic hwLevel_q;
    logic lineValid_q;
    logic restored_q;
    logic [`EXP_W-1:0] duration_q;
    logic [`DLY_W-1:0] delay_q;
    logic [`DLY_W-1:0] delay_d;
    logic exposureActive_q;
    logic exposureDone_q;
    logic triggerMissed_q;
    exposure_trigger_control_pkg::exp_state_t state_q;
    exposure_trigger_control_pkg::exp_state_t state_d;
    localparam int startLag = `START_DELAY_CYC + 1;

    // ---------------------------------------------
    // Trigger selection
    // ---------------------------------------------
    assign activeSource = srcOverride ? triggerSource : `SRC_FIRST_INPUT;
    assign hwLevel = (activeSource == `SRC_FIRST_INPUT) ? first_trigger_input :
                     (activeSource == `SRC_SECOND_INPUT) ? secondTriggerInput : 1'b0;
    wire hwRise = hwLevel && !hwLevel_q;
    wire timedFire = (activeSource == `SRC_TIMED) && timedTrigger;
    wire triggerEvent = hwRise || softTrigger || timedFire;
    wire lineFall = lineValid_q && !lineValid;
    wire idle = (state_q == exposure_trigger_control_pkg::IDLE);
    wire startNow = (state_q == exposure_trigger_control_pkg::WAIT_LINE && lineFall) ||
                    (state_q == exposure_trigger_control_pkg::DELAY && delay_q == `DLY_W'h0);

    // ---------------------------------------------
    // Duration clamp and restore
    // ---------------------------------------------
    wire [`EXP_W-1:0] minCyc = `EXP_W'(`EXP_MIN_CYC);
    wire [`EXP_W-1:0] maxCyc = `EXP_W'(`EXP_MAX_CYC);
    wire [`EXP_W-1:0] reqDur = (!restored_q && storedValid) ? storedExposure : exposureCycles;
    wire [`EXP_W-1:0] clampDur = (reqDur < minCyc) ? minCyc :
                                 (reqDur > maxCyc) ? maxCyc : reqDur;

    assign tmr.load = startNow;
    assign tmr.duration = duration_q;

    // ---------------------------------------------
    // Next state
    // ---------------------------------------------
    always_comb
    begin
        state_d = state_q;
        delay_d = delay_q;
        case (state_q)
            exposure_trigger_control_pkg::IDLE:
            begin
                if (triggerEvent)
                begin
                    if (frameValid)
                        state_d = exposure_trigger_control_pkg::WAIT_LINE;
                    else
                    begin
                        state_d = exposure_trigger_control_pkg::DELAY;
                        delay_d = `DLY_W'(`START_DELAY_CYC - 1);
                    end
                end
            end
            exposure_trigger_control_pkg::WAIT_LINE:
            begin
                if (lineFall)
                    state_d = exposure_trigger_control_pkg::EXPOSE;
            end
            exposure_trigger_control_pkg::DELAY:
            begin
                if (delay_q == `DLY_W'h0)
                    state_d = exposure_trigger_control_pkg::EXPOSE;
                else
                    delay_d = delay_q - `DLY_W'h1;
            end
            exposure_trigger_control_pkg::EXPOSE:
            begin
                if (tmr.done)
                    state_d = exposure_trigger_control_pkg::IDLE;
            end
            default:
                state_d = exposure_trigger_control_pkg::IDLE;
        endcase
    end

    // ---------------------------------------------
    // Registers
    // ---------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_q <= exposure_trigger_control_pkg::IDLE;
            delay_q <= '0;
            hwLevel_q <= 1'b0;
            lineValid_q <= 1'b0;
            restored_q <= 1'b0;
            duration_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            delay_q <= delay_d;
            hwLevel_q <= hwLevel;
            lineValid_q <= lineValid;
            restored_q <= 1'b1;
            if (idle && triggerEvent)
                duration_q <= clampDur;
        end
    end

    // ---------------------------------------------
    // Outputs
    // ---------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            exposureActive_q <= 1'b0;
        else
            exposureActive_q <= (state_d == exposure_trigger_control_pkg::EXPOSE);
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            exposureDone_q <= 1'b0;
        else
            exposureDone_q <= tmr.done;
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            triggerMissed_q <= 1'b0;
        else
            triggerMissed_q <= triggerEvent && !idle;
    end

    exposure_timer timer (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .tmr(tmr.timer)
    );

    assign exposureActive = exposureActive_q;
    assign exposureDone = exposureDone_q;
    assign triggerMissed = triggerMissed_q;

    // ---------------------------------------------
    // Check helpers
    // ---------------------------------------------
    logic [`EXP_W-1:0] activeLen_q;
    logic [`DLY_W-1:0] delayLen_q;
    wire srcIsSecond = srcOverride && (triggerSource == `SRC_SECOND_INPUT);
    wire srcIsTimed = srcOverride && (triggerSource == `SRC_TIMED);
    wire storedInRange = (storedExposure >= minCyc) && (storedExposure <= maxCyc);
    wire liveInRange = (exposureCycles >= minCyc) && (exposureCycles <= maxCyc);

    // Cycles since exposure start
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            activeLen_q <= '0;
        else if (tmr.load)
            activeLen_q <= `EXP_W'h1;
        else if (exposureActive_q)
            activeLen_q <= activeLen_q + `EXP_W'h1;
    end

    // Cycles spent in the fixed delay
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            delayLen_q <= '0;
        else if (idle && triggerEvent && !frameValid)
            delayLen_q <= `DLY_W'h1;
        else if (state_q == exposure_trigger_control_pkg::DELAY)
            delayLen_q <= delayLen_q + `DLY_W'h1;
    end

    // ---------------------------------------------
    // Checks
    // ---------------------------------------------
    sequence trigInFrame;
        idle && triggerEvent && frameValid;
    endsequence
    sequence trigOutFrame;
        idle && triggerEvent && !frameValid;
    endsequence
    sequence lineWait;
        state_q == exposure_trigger_control_pkg::WAIT_LINE && !lineFall;
    endsequence
    sequence lineEdge;
        state_q == exposure_trigger_control_pkg::WAIT_LINE && lineFall;
    endsequence
    sequence delayRun;
        state_q == exposure_trigger_control_pkg::DELAY && delay_q != `DLY_W'h0;
    endsequence
    sequence delayEnd;
        state_q == exposure_trigger_control_pkg::DELAY && delay_q == `DLY_W'h0;
    endsequence
    sequence expoRun;
        exposureActive_q && !tmr.done;
    endsequence
    sequence busyTrig;
        !idle && triggerEvent;
    endsequence

    chk_start_needs_trigger: assert property (@(posedge clk_sys) disable iff (sys_rst)
        idle && !triggerEvent |=> idle) else $error("Left idle without trigger");
    chk_soft_trigger_start: assert property (@(posedge clk_sys) disable iff (sys_rst)
        idle && softTrigger |=> !idle) else $error("Soft trigger ignored");
    chk_rise_edge_start: assert property (@(posedge clk_sys) disable iff (sys_rst)
        idle && hwRise |=> !idle) else $error("Rising edge ignored");
    chk_default_source: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !srcOverride |-> hwLevel == first_trigger_input) else $error("Wrong default source");
    chk_duration_range: assert property (@(posedge clk_sys) disable iff (sys_rst)
        tmr.load |-> duration_q >= minCyc && duration_q <= maxCyc) else $error("Duration out of range");
    chk_line_aligned: assert property (@(posedge clk_sys) disable iff (sys_rst)
        trigInFrame |=> state_q == exposure_trigger_control_pkg::WAIT_LINE) else $error("Not waiting for line");
    chk_line_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
        lineWait |=> !exposureActive_q) else $error("Started before line fall");
    chk_line_start: assert property (@(posedge clk_sys) disable iff (sys_rst)
        lineEdge |=> exposureActive_q && tmr.busy) else $error("No start at line fall");
    chk_fixed_delay: assert property (@(posedge clk_sys) disable iff (sys_rst)
        trigOutFrame |-> ##startLag exposureActive_q) else $error("Fixed delay wrong");
    chk_delay_holds: assert property (@(posedge clk_sys) disable iff (sys_rst)
        delayRun |=> !exposureActive_q) else $error("Started during delay");
    chk_delay_count: assert property (@(posedge clk_sys) disable iff (sys_rst)
        delayEnd |-> delayLen_q == `DLY_W'(`START_DELAY_CYC)) else $error("Delay length wrong");
    chk_duration_stable: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !idle |=> $stable(duration_q)) else $error("Duration changed mid exposure");
    chk_done_ends: assert property (@(posedge clk_sys) disable iff (sys_rst)
        tmr.done |=> idle && exposureDone_q) else $error("Exposure did not end");

    // ---------------------------------------------
    // Idle, missed-trigger, source and duration checks
    // ---------------------------------------------
    chk_idle_inactive: assert property (@(posedge clk_sys) disable iff (sys_rst)
        idle |-> !exposureActive_q) else $error("Active while idle");
    chk_missed_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
        busyTrig |=> triggerMissed_q) else $error("Dropped trigger not flagged");
    chk_timed_source: assert property (@(posedge clk_sys) disable iff (sys_rst)
        idle && srcIsTimed && timedTrigger |=> !idle) else $error("Timed trigger ignored");
    chk_second_source: assert property (@(posedge clk_sys) disable iff (sys_rst)
        srcIsSecond |-> hwLevel == secondTriggerInput) else $error("Second line not selected");
    chk_restore_used: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !restored_q && storedValid && storedInRange && idle && triggerEvent |=> duration_q == $past(storedExposure))
        else $error("Stored duration not used");
    chk_live_duration: assert property (@(posedge clk_sys) disable iff (sys_rst)
        restored_q && liveInRange && idle && triggerEvent |=> duration_q == $past(exposureCycles))
        else $error("Live duration not used");

    // ---------------------------------------------
    // Exposure timing checks
    // ---------------------------------------------
    chk_frame_wait: assert property (@(posedge clk_sys) disable iff (sys_rst)
        trigInFrame |=> !exposureActive_q) else $error("In-frame start too early");
    chk_delay_loaded: assert property (@(posedge clk_sys) disable iff (sys_rst)
        trigOutFrame |=> delay_q == `DLY_W'(`START_DELAY_CYC - 1)) else $error("Delay not loaded");
    chk_load_starts: assert property (@(posedge clk_sys) disable iff (sys_rst)
        tmr.load |=> exposureActive_q && tmr.busy) else $error("Load did not start exposure");
    chk_busy_no_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
        tmr.busy |-> !tmr.load) else $error("Load while timer busy");
    chk_exposure_length: assert property (@(posedge clk_sys) disable iff (sys_rst)
        tmr.done |-> activeLen_q == duration_q + `EXP_W'h1) else $error("Exposure length wrong");
    chk_active_holds: assert property (@(posedge clk_sys) disable iff (sys_rst)
        expoRun |=> exposureActive_q) else $error("Exposure ended early");
    chk_active_falls: assert property (@(posedge clk_sys) disable iff (sys_rst)
        tmr.done |=> !exposureActive_q) else $error("Exposure did not stop");
    chk_done_pulse: assert property (@(posedge clk_sys) disable iff (sys_rst)
        exposureDone_q |=> !exposureDone_q) else $error("Done longer than one cycle");
endmodule

// File: exposure_trigger_control_defs.svh
// Constants for the exposure trigger block
// Assumes a 40 MHz system clock
`ifndef EXPOSURE_TRIGGER_CONTROL_DEFS_SVH
`define EXPOSURE_TRIGGER_CONTROL_DEFS_SVH

`define CLK_PERIOD_NS 25
`define EXP_MIN_US 60
`define EXP_MAX_S 60
`define EXP_MIN_CYC ((`EXP_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EXP_MAX_CYC ((`EXP_MAX_S * 64'd1000000000) / `CLK_PERIOD_NS)
`define EXP_W 32
`define SRC_W 2
`define SRC_FIRST_INPUT 2'h0
`define SRC_SECOND_INPUT 2'h1
`define SRC_TIMED 2'h2
`define START_DELAY_NS 200
`define START_DELAY_CYC ((`START_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DLY_W 8

`endif

// File: exposure_trigger_control_pkg.sv
// Types for the exposure trigger block
// Assumes the defs header is compiled alongside
package exposure_trigger_control_pkg;
    typedef enum logic [2:0] {IDLE, WAIT_LINE, DELAY, EXPOSE} exp_state_t;
endpackage

// File: exposure_timer_if.sv
// Carrier between the control logic and the exposure timer
// Assumes one clock domain
`timescale 1ns/1ps
`include "exposure_trigger_control_defs.svh"
interface exposure_timer_if;
    logic load;
    logic [`EXP_W-1:0] duration;
    logic busy;
    logic done;
    modport ctrl (output load, output duration, input busy, input done);
    modport timer (input load, input duration, output busy, output done);
endinterface

// File: exposure_timer.sv
// Down counter that times one exposure
// Assumes load is a one-cycle pulse from the control logic
`timescale 1ns/1ps
`include "exposure_trigger_control_defs.svh"
module exposure_timer (
    input wire logic clk_sys,
    input wire logic sys_rst,
    exposure_timer_if.timer tmr
);
    logic [`EXP_W-1:0] count_q;
    logic busy_q;
    logic done_q;
    wire expireNow = busy_q && (count_q == `EXP_W'h1);

    // ---------------------------------------------
    // Counter
    // ---------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            count_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            done_q <= expireNow;
            if (tmr.load)
            begin
                count_q <= tmr.duration;
                busy_q <= 1'b1;
            end
            else if (busy_q)
            begin
                count_q <= count_q - `EXP_W'h1;
                busy_q <= !expireNow;
            end
        end
    end

    assign tmr.busy = busy_q;
    assign tmr.done = done_q;

    chk_timer_expires: assert property (@(posedge clk_sys) disable iff (sys_rst)
        expireNow |=> done_q && !busy_q) else $error("Timer did not expire");
endmodule

// File: readout_model.sv
// Readout engine model driving frame and line valid
// Assumes one clock; outputs change just after rising edges
`timescale 1ns/1ps
module readout_model (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic runFrame,
    output logic frameValid,
    output logic lineValid
);
    // ----
    // Line pattern: 7 high, 6 low
    // ----
    int phase;
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            phase <= 0;
            frameValid <= 1'h0;
            lineValid <= 1'h0;
        end
        else
        begin
            phase <= (phase + 1) % 13;
            frameValid <= runFrame;
            lineValid <= runFrame && (phase < 7);
        end
    end
endmodule

// File: exposure_trigger_control_tb_top.sv
// Testbench for the exposure trigger block
// Assumes the readout model and the design files
`timescale 1ns/1ps
`include "exposure_trigger_control_defs.svh"
module exposure_trigger_control_tb_top;
    // ----
    // Stimulus, model and checks
    // ----
    logic clk_sys = 1'h0;
    logic sys_rst = 1'h1;
    logic softTrigger = 1'h0;
    logic first_trigger_input = 1'h0;
    logic secondTriggerInput = 1'h0;
    logic timedTrigger = 1'h0;
    logic [`SRC_W-1:0] triggerSource = `SRC_FIRST_INPUT;
    logic srcOverride = 1'h0;
    logic [`EXP_W-1:0] exposureCycles = 32'h00000064;
    logic [`EXP_W-1:0] storedExposure = 32'h00000bb8;
    logic storedValid = 1'h1;
    logic runFrame = 1'h0;
    logic frameValid, lineValid, exposureActive, exposureDone, triggerMissed, miss, lvWas;
    int failures = 0;
    int tests_run = 0;
    int seed = 59649;
    int lvAge = 0;
    int dly = `START_DELAY_CYC + 1;
    int startAge = 0;
    int lenQ[$];
    always #(`CLK_PERIOD_NS / 2.0) clk_sys = ~clk_sys;
    readout_model far_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .runFrame(runFrame),
        .frameValid(frameValid), .lineValid(lineValid));
    exposure_trigger_control dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .softTrigger(softTrigger),
        .first_trigger_input(first_trigger_input), .secondTriggerInput(secondTriggerInput),
        .timedTrigger(timedTrigger), .triggerSource(triggerSource), .srcOverride(srcOverride),
        .exposureCycles(exposureCycles), .storedExposure(storedExposure), .storedValid(storedValid),
        .frameValid(frameValid), .lineValid(lineValid), .exposureActive(exposureActive),
        .exposureDone(exposureDone), .triggerMissed(triggerMissed));
    function automatic int clampLen(input int d);
        return (d < `EXP_MIN_CYC) ? `EXP_MIN_CYC : d;
    endfunction
    task automatic close_out;
        $display("tests_run %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input int lo, input int hi);
        tests_run++;
        if ((^got === 1'hx) || (got < lo) || (got > hi))
        begin
            failures++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, lo);
        end
    endtask
    task automatic step;
        @(negedge clk_sys);
        lvAge = (lvWas === 1'h1 && lineValid === 1'h0) ? 0 : lvAge + 1;
        lvWas = lineValid;
    endtask
    task automatic measure(input int sel, input int dlo, input int dhi, input int len);
        int n;
        int m;
        int want;
        n = 1;
        m = 0;
        lenQ.push_back(len);
        case (sel)
            0: softTrigger = 1'h1;
            1: first_trigger_input = 1'h1;
            2: secondTriggerInput = 1'h1;
            default: timedTrigger = 1'h1;
        endcase
        step();
        {softTrigger, first_trigger_input, secondTriggerInput, timedTrigger} = 4'h0;
        while (exposureActive !== 1'h1 && n < 300)
        begin
            step();
            n++;
        end
        startAge = lvAge;
        check(n, dlo, dhi);
        while (exposureActive === 1'h1 && m < 20000)
        begin
            step();
            m++;
        end
        want = lenQ.pop_front();
        check(m, want, want + 1);
        check(exposureDone, 1, 1);
    endtask
    initial
    begin
        #(60000 * `CLK_PERIOD_NS);
        failures++;
        close_out();
    end
    initial
    begin
        repeat (5) step();
        check(exposureActive | exposureDone | triggerMissed, 0, 0);
        sys_rst = 1'h0;
        measure(0, dly, dly, 3000);
        storedValid = 1'h0;
        measure(0, dly, dly, `EXP_MIN_CYC);
        secondTriggerInput = 1'h1;
        repeat (20) step();
        secondTriggerInput = 1'h0;
        check(exposureActive, 0, 0);
        for (int i = 1; i < 4; i++)
        begin
            exposureCycles = `EXP_MIN_CYC + ($random(seed) & 32'h000007ff);
            srcOverride = (i > 1);
            triggerSource = (i == 2) ? `SRC_SECOND_INPUT : `SRC_TIMED;
            measure(i, dly, dly, clampLen(exposureCycles));
        end
        exposureCycles = 32'h00000bb8;
        fork
            measure(0, dly, dly, 3000);
            begin
                repeat (20) step();
                exposureCycles = 32'h00001388;
                softTrigger = 1'h1;
                step();
                softTrigger = 1'h0;
                miss = triggerMissed;
                step();
                check(miss | triggerMissed, 1, 1);
            end
        join
        measure(0, dly, dly, 5000);
        exposureCycles = `EXP_MIN_CYC;
        runFrame = 1'h1;
        repeat (30) step();
        measure(1 - srcOverride, 2, 14, `EXP_MIN_CYC);
        check(startAge, 1, 1);
        close_out();
    end
endmodule
